// *** common/acs_defines.vh ***
// constants for the adc channel sequencer: addresses, bit positions, reset values
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

`define ACS_ADDR_IRQ_FLAGS  32'h4006808C
`define ACS_ADDR_SEQ_CTRL   32'h40068090
`define ACS_ADDR_REPEAT     32'h40068094
`define ACS_ADDR_STATE      32'h40068098
`define ACS_ADDR_MASK       32'h4006809C

`define ACS_BIT_CONV_FLAG   0
`define ACS_BIT_SEQ_FLAG    1
`define ACS_BIT_RUN         0
`define ACS_BIT_RESTART     1
`define ACS_BIT_STALL       2
`define ACS_BIT_IRQ_EN      3
`define ACS_BIT_CONV_BUSY   0
`define ACS_BIT_STALLED     1
`define ACS_BIT_SEQ_BUSY    2

`define ACS_CHAN_COUNT      30
`define ACS_CHAN_IDX_W      5
`define ACS_PTR_W           6
`define ACS_INTERVAL_W      8
`define ACS_INTERVAL_HALT   8'hFF
`define ACS_TICK_CYCLES     1
`define ACS_PRE_W           8

`define ACS_RST_MASK        30'h00000000
`define ACS_RST_INTERVAL    8'h00
`define ACS_RST_CHAN        5'h00
`define ACS_PTR_FIRST       6'h00
`define ACS_DATA_ZERO       32'h00000000

`endif

// *** hdl/acs_chan_pick.v ***
// lowest selected channel at or above a start index
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_chan_pick #(
  parameter N  = `ACS_CHAN_COUNT,
  parameter IW = `ACS_CHAN_IDX_W,
  parameter PW = `ACS_PTR_W
) (
  // selection
  input  wire [N-1:0]  mask,
  input  wire [PW-1:0] start,
  // result
  output wire          found,
  output wire [IW-1:0] index
);

  wire [N-1:0]      cand;
  wire [N:0]        seen;
  wire [(N+1)*IW-1:0] acc;

  assign seen[0]     = 1'b0;
  assign acc[IW-1:0] = {IW{1'b0}};

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
      localparam integer  POSN = i;
      localparam [PW-1:0] POS  = POSN[PW-1:0];
      localparam [IW-1:0] POSI = POSN[IW-1:0];
      // ascending order: first candidate not shadowed by a lower one
      assign cand[i]                  = mask[i] & (POS >= start);
      assign seen[i+1]                = seen[i] | cand[i];
      assign acc[(i+1)*IW +: IW]      = acc[i*IW +: IW] |
                                        ({IW{cand[i] & ~seen[i]}} & POSI);
    end
  endgenerate

  assign found = seen[N];
  assign index = acc[N*IW +: IW];

endmodule // acs_chan_pick

// *** hdl/acs_gap_timer.v ***
// delay between passes, counted in ticks of a prescaled clock
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_gap_timer #(
  parameter W    = `ACS_INTERVAL_W,
  parameter PSW  = `ACS_PRE_W,
  parameter TICK = `ACS_TICK_CYCLES
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // control
  input  wire         start,
  input  wire         cancel,
  input  wire [W-1:0] ticks,
  // result
  output wire         done
);

  localparam integer   PRE_LAST_I = TICK - 1;
  localparam [PSW-1:0] PRE_LAST   = PRE_LAST_I[PSW-1:0];

  reg           active_ff;
  reg [W-1:0]   cnt_ff;
  reg [PSW-1:0] pre_ff;

  // zero ticks finishes one cycle after start
  assign done = active_ff & (cnt_ff == {W{1'b0}});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      active_ff <= 1'b0;
      cnt_ff    <= {W{1'b0}};
      pre_ff    <= {PSW{1'b0}};
    end else if (start) begin
      active_ff <= 1'b1;
      cnt_ff    <= ticks;
      pre_ff    <= {PSW{1'b0}};
    end else if (cancel | done) begin
      active_ff <= 1'b0;
    end else if (active_ff) begin
      if (pre_ff == PRE_LAST) begin
        pre_ff <= {PSW{1'b0}};
        cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end else begin
        pre_ff <= pre_ff + {{(PSW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // acs_gap_timer

// *** hdl/acs_top.v ***
// adc channel sequencer: apb registers, pass state machine, adc core handshake
`timescale 1ns/1ps
`include "acs_defines.vh"

module acs_top #(
  parameter N    = `ACS_CHAN_COUNT,
  parameter IW   = `ACS_CHAN_IDX_W,
  parameter PW   = `ACS_PTR_W,
  parameter TW   = `ACS_INTERVAL_W,
  parameter TICK = `ACS_TICK_CYCLES
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // adc conversion core, same clock
  output wire          cnv_start,
  output wire [IW-1:0] cnv_chan,
  input  wire          cnv_done,
  // status levels
  output wire          sequence_done_flag,
  output wire          conversion_done_flag,
  output wire          sequencer_busy
);

  // one-hot states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PICK = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_GAP  = 4'h8;

  // registers
  reg [3:0]    state_ff;
  reg [3:0]    nxt_state;
  reg [PW-1:0] ptr_ff;
  reg [PW-1:0] nxt_ptr;
  reg          any_ff;
  reg          nxt_any;
  reg          restart_pend_ff;
  reg          nxt_restart_pend;
  reg          cnv_start_ff;
  reg          nxt_cnv_start;
  reg [IW-1:0] cnv_chan_ff;
  reg [IW-1:0] nxt_cnv_chan;
  reg          cnv_busy_ff;
  reg          irq_en_ff;
  reg          stall_ff;
  reg [TW-1:0] interval_ff;
  reg [N-1:0]  mask_ff;
  reg          seq_flag_ff;
  reg          nxt_seq_flag;
  reg          cnv_flag_ff;
  reg          nxt_cnv_flag;
  reg [31:0]   prdata_ff;
  reg [31:0]   nxt_prdata;
  reg          pass_end;
  reg          gap_start;
  reg          gap_cancel;

  // bus decode
  wire         setup_ph;
  wire         access_ph;
  wire         wr_acc;
  wire         rd_acc;
  wire         hit_irq;
  wire         hit_ctrl;
  wire         hit_rep;
  wire         hit_state;
  wire         hit_mask;
  wire         mapped;
  wire         run_strobe;
  wire         restart_strobe;

  // channel search and timer
  wire         pick_found;
  wire [IW-1:0] pick_index;
  wire         gap_done;
  wire         is_idle;
  wire         stalled;

  // apb: zero wait states, read data captured in the setup cycle
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = access_ph;
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;

  assign hit_irq   = (paddr == `ACS_ADDR_IRQ_FLAGS);
  assign hit_ctrl  = (paddr == `ACS_ADDR_SEQ_CTRL);
  assign hit_rep   = (paddr == `ACS_ADDR_REPEAT);
  assign hit_state = (paddr == `ACS_ADDR_STATE);
  assign hit_mask  = (paddr == `ACS_ADDR_MASK);
  assign mapped    = hit_irq | hit_ctrl | hit_rep | hit_state | hit_mask;
  assign pslverr   = access_ph & ~mapped;

  // run is never stored and restart only as a pending request, so the bits read back as zero
  assign run_strobe     = wr_acc & hit_ctrl & pwdata[`ACS_BIT_RUN];
  assign restart_strobe = wr_acc & hit_ctrl & pwdata[`ACS_BIT_RESTART];

  assign is_idle  = state_ff[0];
  // stalled once the conversion in flight has drained
  assign stalled  = stall_ff & ~is_idle & ~cnv_busy_ff;

  assign prdata               = prdata_ff;
  assign cnv_start            = cnv_start_ff;
  assign cnv_chan             = cnv_chan_ff;
  assign sequence_done_flag   = seq_flag_ff;
  assign conversion_done_flag = cnv_flag_ff;
  assign sequencer_busy       = ~is_idle;

  acs_chan_pick #(
    .N  (N),
    .IW (IW),
    .PW (PW)
  ) u_pick (
    .mask  (mask_ff),
    .start (ptr_ff),
    .found (pick_found),
    .index (pick_index)
  );

  acs_gap_timer #(
    .W    (TW),
    .TICK (TICK)
  ) u_gap (
    .clk    (clk),
    .rst    (rst),
    .start  (gap_start),
    .cancel (gap_cancel),
    .ticks  (interval_ff),
    .done   (gap_done)
  );

  // read mux
  always @* begin
    nxt_prdata = prdata_ff;
    if (setup_ph) begin
      nxt_prdata = `ACS_DATA_ZERO;
      if (hit_irq) begin
        nxt_prdata[`ACS_BIT_SEQ_FLAG]  = seq_flag_ff;
        nxt_prdata[`ACS_BIT_CONV_FLAG] = cnv_flag_ff;
      end else if (hit_ctrl) begin
        nxt_prdata[`ACS_BIT_IRQ_EN] = irq_en_ff;
        nxt_prdata[`ACS_BIT_STALL]  = stall_ff;
      end else if (hit_rep) begin
        nxt_prdata[TW-1:0] = interval_ff;
      end else if (hit_state) begin
        nxt_prdata[`ACS_BIT_SEQ_BUSY]  = ~is_idle;
        nxt_prdata[`ACS_BIT_STALLED]   = stalled;
        nxt_prdata[`ACS_BIT_CONV_BUSY] = cnv_busy_ff;
      end else if (hit_mask) begin
        nxt_prdata[N-1:0] = mask_ff;
      end
    end
  end

  // sequencer
  always @* begin
    nxt_state        = state_ff;
    nxt_ptr          = ptr_ff;
    nxt_any          = any_ff;
    nxt_restart_pend = restart_pend_ff;
    nxt_cnv_start    = 1'b0;
    nxt_cnv_chan     = cnv_chan_ff;
    pass_end         = 1'b0;
    gap_start        = 1'b0;
    gap_cancel       = 1'b0;
    if (restart_strobe & ~is_idle) begin
      nxt_restart_pend = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_restart_pend = 1'b0;
        if (run_strobe) begin
          nxt_state = ST_PICK;
          nxt_ptr   = `ACS_PTR_FIRST;
          nxt_any   = 1'b0;
        end
      end
      ST_PICK: begin
        if (restart_pend_ff) begin
          // back to the first selected channel, pass starts over
          nxt_ptr          = `ACS_PTR_FIRST;
          nxt_any          = 1'b0;
          nxt_restart_pend = 1'b0;
        end else if (stall_ff) begin
          nxt_state = ST_PICK;
        end else if (pick_found) begin
          nxt_cnv_start = 1'b1;
          nxt_cnv_chan  = pick_index;
          nxt_ptr       = {1'b0, pick_index} + {{(PW-1){1'b0}}, 1'b1};
          nxt_any       = 1'b1;
          nxt_state     = ST_CONV;
        end else if (~any_ff) begin
          // empty mask: nothing to convert, stop without an event
          nxt_state = ST_IDLE;
        end else begin
          // halt decision taken only here, so a late 255 lets the pass finish
          pass_end = 1'b1;
          if (interval_ff == `ACS_INTERVAL_HALT) begin
            nxt_state = ST_IDLE;
          end else begin
            gap_start = 1'b1;
            nxt_state = ST_GAP;
          end
        end
      end
      ST_CONV: begin
        if (cnv_done) begin
          nxt_state = ST_PICK;
        end
      end
      ST_GAP: begin
        if (restart_pend_ff) begin
          gap_cancel       = 1'b1;
          nxt_restart_pend = 1'b0;
          nxt_ptr          = `ACS_PTR_FIRST;
          nxt_any          = 1'b0;
          nxt_state        = ST_PICK;
        end else if (gap_done) begin
          nxt_ptr   = `ACS_PTR_FIRST;
          nxt_any   = 1'b0;
          nxt_state = ST_PICK;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // event flags: cleared by reading them back, only the bits seen as 1
  always @* begin
    nxt_seq_flag = seq_flag_ff;
    nxt_cnv_flag = cnv_flag_ff;
    if (rd_acc & hit_irq) begin
      nxt_seq_flag = seq_flag_ff & ~prdata_ff[`ACS_BIT_SEQ_FLAG];
      nxt_cnv_flag = cnv_flag_ff & ~prdata_ff[`ACS_BIT_CONV_FLAG];
    end
    // set wins over a clear in the same cycle
    if (pass_end & irq_en_ff) begin
      nxt_seq_flag = 1'b1;
    end
    if (cnv_done & cnv_busy_ff) begin
      nxt_cnv_flag = 1'b1;
    end
  end

  // state registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff        <= ST_IDLE;
      ptr_ff          <= `ACS_PTR_FIRST;
      any_ff          <= 1'b0;
      restart_pend_ff <= 1'b0;
      cnv_start_ff    <= 1'b0;
      cnv_chan_ff     <= `ACS_RST_CHAN;
      seq_flag_ff     <= 1'b0;
      cnv_flag_ff     <= 1'b0;
      prdata_ff       <= `ACS_DATA_ZERO;
    end else begin
      state_ff        <= nxt_state;
      ptr_ff          <= nxt_ptr;
      any_ff          <= nxt_any;
      restart_pend_ff <= nxt_restart_pend;
      cnv_start_ff    <= nxt_cnv_start;
      cnv_chan_ff     <= nxt_cnv_chan;
      seq_flag_ff     <= nxt_seq_flag;
      cnv_flag_ff     <= nxt_cnv_flag;
      prdata_ff       <= nxt_prdata;
    end
  end

  // conversion busy from start pulse to done
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnv_busy_ff <= 1'b0;
    end else if (cnv_start_ff) begin
      cnv_busy_ff <= 1'b1;
    end else if (cnv_done) begin
      cnv_busy_ff <= 1'b0;
    end
  end

  // software configuration; changing it while busy is the caller's hazard
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_ff   <= 1'b0;
      stall_ff    <= 1'b0;
      interval_ff <= `ACS_RST_INTERVAL;
      mask_ff     <= `ACS_RST_MASK;
    end else if (wr_acc) begin
      if (hit_ctrl) begin
        irq_en_ff <= pwdata[`ACS_BIT_IRQ_EN];
        stall_ff  <= pwdata[`ACS_BIT_STALL];
      end else if (hit_rep) begin
        interval_ff <= pwdata[TW-1:0];
      end else if (hit_mask) begin
        mask_ff <= pwdata[N-1:0];
      end
    end
  end

endmodule // acs_top

// *** bench/acs_sva.sv ***
// port assertions for the adc channel sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_sva #(
  parameter IW = `ACS_CHAN_IDX_W
) (
  // clock and reset
  input logic          clk,
  input logic          rst,
  // apb
  input logic          psel,
  input logic          penable,
  input logic          pwrite,
  input logic [31:0]   paddr,
  input logic [31:0]   pwdata,
  input logic [31:0]   prdata,
  input logic          pready,
  input logic          pslverr,
  // adc core
  input logic          cnv_start,
  input logic [IW-1:0] cnv_chan,
  input logic          cnv_done,
  // status
  input logic          sequence_done_flag,
  input logic          conversion_done_flag,
  input logic          sequencer_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  property p_start_pulse; cnv_start |=> !cnv_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  property p_idle_quiet; !sequencer_busy |-> !cnv_start; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("start while idle");
  property p_chan_hold; !cnv_start |-> $stable(cnv_chan); endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved between starts");
  property p_run; acc && pwrite && paddr == `ACS_ADDR_SEQ_CTRL && pwdata[0] |=> sequencer_busy;
  endproperty
  a_run: assert property (p_run)
    else $error("run write did not make busy");
  property p_flag_clr; rd && paddr == `ACS_ADDR_IRQ_FLAGS && prdata[`ACS_BIT_SEQ_FLAG]
    |=> !sequence_done_flag; endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("sequence flag kept after read");
  property p_conv_flag; $rose(conversion_done_flag) |-> $past(cnv_done); endproperty
  a_conv_flag: assert property (p_conv_flag)
    else $error("conversion flag without done");
  property p_ctrl_rd; rd && paddr == `ACS_ADDR_SEQ_CTRL |-> prdata[1:0] == 2'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("strobe bits read back");
  property p_state_rd; rd && paddr == `ACS_ADDR_STATE |-> prdata[2] == $past(sequencer_busy);
  endproperty
  a_state_rd: assert property (p_state_rd)
    else $error("busy bit mismatch");
endmodule // acs_sva
bind acs_top acs_sva #(.IW(IW)) u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cnv_start(cnv_start), .cnv_chan(cnv_chan), .cnv_done(cnv_done),
  .sequence_done_flag(sequence_done_flag), .conversion_done_flag(conversion_done_flag),
  .sequencer_busy(sequencer_busy));

// *** bench/acs_adc_model.sv ***
// behavioural adc core: one conversion at a time, latency taken from the lat input
`timescale 1ns/1ps
module acs_adc_model (
  // clock and reset
  input  logic       clk,
  input  logic       rst,
  // start side
  input  logic       cnv_start,
  input  logic [4:0] cnv_chan,
  input  logic [7:0] lat,
  // done pulse
  output logic       cnv_done
);
  logic [4:0] seen [$];
  logic [7:0] cnt_ff;
  // latency from the bench, so prompt and slow answers both occur
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnv_done <= 1'b0;
      cnt_ff   <= 8'h00;
    end else begin
      cnv_done <= 1'b0;
      if (cnv_start) begin
        seen.push_back(cnv_chan);
        cnt_ff <= lat;
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) cnv_done <= 1'b1;
      end
    end
  end
endmodule // acs_adc_model

// *** bench/acs_tb_top.sv ***
// self-checking bench for the adc channel sequencer
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  lat = 8'h02;
  logic [31:0] d;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, cnv_start, cnv_done, sflag, cflag, busy;
  wire  [4:0]  cnv_chan;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #2 clk = ~clk;
  acs_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnv_start(cnv_start), .cnv_chan(cnv_chan), .cnv_done(cnv_done),
    .sequence_done_flag(sflag), .conversion_done_flag(cflag), .sequencer_busy(busy));
  acs_adc_model adc (.clk(clk), .rst(rst), .cnv_start(cnv_start), .cnv_chan(cnv_chan),
    .lat(lat), .cnv_done(cnv_done));
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard; a normal run takes well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test;
    end
  end
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // one apb transfer; idle cycle after it so psel is never set twice in a step
  task xf(input logic w, input logic [31:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0);
    chk(nm, x, d);
  endtask
  task idle;
    do xf(1'b0, `ACS_ADDR_STATE, 32'h0); while (d[2] !== 1'b0);
  endtask
  task go(input logic [31:0] m, input logic [31:0] c);
    adc.seen.delete();
    xf(1'b1, `ACS_ADDR_MASK, m);
    xf(1'b1, `ACS_ADDR_SEQ_CTRL, c);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("flags", `ACS_ADDR_IRQ_FLAGS, 32'h0);
    rdc("ctrl", `ACS_ADDR_SEQ_CTRL, 32'h0);
    rdc("repeat", `ACS_ADDR_REPEAT, 32'h0);
    rdc("state", `ACS_ADDR_STATE, 32'h0);
    rdc("mask", `ACS_ADDR_MASK, 32'h0);
    xf(1'b0, 32'h400680A0, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    xf(1'b1, `ACS_ADDR_SEQ_CTRL, 32'h0000000F);
    rdc("ctrl", `ACS_ADDR_SEQ_CTRL, 32'h0000000C);
    xf(1'b1, `ACS_ADDR_SEQ_CTRL, 32'h0);
    xf(1'b1, `ACS_ADDR_REPEAT, 32'h000001FE);
    rdc("repeat", `ACS_ADDR_REPEAT, 32'h000000FE);
    xf(1'b1, `ACS_ADDR_REPEAT, 32'h000000FF);
    $display("test regs done");
    lat <= 8'h05;
    go(32'hFFFFFFFF, 32'h9);
    idle;
    chk("count", 32'd30, adc.seen.size());
    for (int i = 0; i < 30; i++) chk("chan", i, adc.seen[i]);
    chk("busy", 32'h0, {31'h0, busy});
    chk("sflag", 32'h1, {31'h0, sflag});
    chk("cflag", 32'h1, {31'h0, cflag});
    rdc("flags", `ACS_ADDR_IRQ_FLAGS, 32'h3);
    rdc("flags", `ACS_ADDR_IRQ_FLAGS, 32'h0);
    chk("sflag", 32'h0, {31'h0, sflag});
    chk("cflag", 32'h0, {31'h0, cflag});
    go(32'h20000005, 32'h1);
    idle;
    chk("last", 32'd29, adc.seen[$]);
    rdc("flags", `ACS_ADDR_IRQ_FLAGS, 32'h1);
    $display("test single done");
    lat <= 8'h02;
    xf(1'b1, `ACS_ADDR_REPEAT, 32'h03);
    go(32'h3, 32'h9);
    while (adc.seen.size() < 5) @(posedge clk);
    xf(1'b1, `ACS_ADDR_REPEAT, 32'hFF);
    idle;
    chk("whole", 32'h0, adc.seen.size() % 2);
    chk("last", 32'h1, adc.seen[$]);
    rdc("flags", `ACS_ADDR_IRQ_FLAGS, 32'h3);
    $display("test repeat done");
    go(32'h3, 32'h5);
    repeat (4) @(posedge clk);
    rdc("state", `ACS_ADDR_STATE, 32'h6);
    chk("none", 32'h0, adc.seen.size());
    chk("busy", 32'h1, {31'h0, busy});
    xf(1'b1, `ACS_ADDR_SEQ_CTRL, 32'h0);
    idle;
    chk("count", 32'h2, adc.seen.size());
    $display("test stall done");
    lat <= 8'd20;
    go(32'h3, 32'h1);
    xf(1'b1, `ACS_ADDR_SEQ_CTRL, 32'h2);
    rdc("state", `ACS_ADDR_STATE, 32'h5);
    idle;
    chk("count", 32'h3, adc.seen.size());
    chk("chan", 32'h0, adc.seen[1]);
    chk("chan", 32'h1, adc.seen[2]);
    $display("test restart done");
    finish_test;
  end
endmodule // acs_tb_top
